// ===== rtl/sas_seq.sv
`timescale 1ns/1ps
module sas_seq import sas_pkg::*; #(
    parameter int unsigned DIV = INT_DIV
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Wishbone slave
    input  wire sas_wb_req_t       wb_req,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Conversion control pins
    input  wire logic              start_conv_n,
    input  wire logic              ext_clk_pin,
    output logic                   conv_done_flag,
    // Result pins, bit 11 is result_msb, bit 0 is result_lsb
    input  wire logic              high_byte_out_en_n,
    input  wire logic              low_nibble_out_en_n,
    output logic [RES_W-1:0]       result_o,
    output logic                   result_hi_oe_n,
    output logic                   result_lo_oe_n,
    // Analog front end
    input  wire logic              comp_hi,
    output sas_afe_t               afe
);

    typedef struct packed {
        logic [3:0]       period;
        logic             hold;
        logic             start_seen;
        logic             done;
        logic [RES_W-1:0] sar;
        logic [RES_W-1:0] result;
        logic             ext_sel;
        logic             ack;
        logic [31:0]      rdat;
        logic [1:0]       start_conv_n_s;
        logic [1:0]       comp_s;
        logic [1:0]       oem_s;
        logic [1:0]       oel_s;
    } sas_st_t;

    sas_st_t s_r;
    sas_st_t s_nxt;
    logic    tick;
    logic    start_conv_n_low;
    logic    comp_bit;
    logic    bus_req;

    // ********************************************************
    // Conversion clock source
    // ********************************************************
    // Internal clock stops while parked in period 2
    sas_conv_clk #(
        .DIV         (DIV)
    ) u_clk (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .ext_sel     (s_r.ext_sel),
        .run         (~s_r.hold),
        .ext_clk_pin (ext_clk_pin),
        .tick        (tick)
    );

    // Synchronised pin levels, second stage only
    assign start_conv_n_low = ~s_r.start_conv_n_s[1];
    assign comp_bit = s_r.comp_s[1];
    assign bus_req  = wb_req.cyc & wb_req.stb & ~s_r.ack;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic [3:0] k;
        k            = P_LAST - s_r.period;
        s_nxt        = s_r;
        s_nxt.start_conv_n_s = {s_r.start_conv_n_s[0], start_conv_n};
        s_nxt.comp_s = {s_r.comp_s[0], comp_hi};
        s_nxt.oem_s  = {s_r.oem_s[0], high_byte_out_en_n};
        s_nxt.oel_s  = {s_r.oel_s[0], low_nibble_out_en_n};

        // Start is only looked at once period 15 is over
        if (s_r.period == P_FIRST && start_conv_n_low) begin
            s_nxt.start_seen = 1'b1;
        end

        // Parked in period 2: a start drops the flag and releases the gate
        if (s_r.hold && start_conv_n_low) begin
            s_nxt.hold = 1'b0;
            s_nxt.done = 1'b0;
        end

        // Every step happens on a conversion clock rising edge
        if (tick && !s_r.hold) begin
            if (s_r.period == P_FIRST) begin
                s_nxt.period     = P_GATE;
                s_nxt.start_seen = 1'b0;
                if (s_r.start_seen || start_conv_n_low) begin
                    s_nxt.done = 1'b0;
                end else begin
                    s_nxt.hold = 1'b1;
                end
            end else if (s_r.period == P_TRACK_LAST) begin
                s_nxt.period = P_MSB;
                s_nxt.sar    = SAR_MSB_ONLY;
            end else if (s_r.period == P_LAST) begin
                s_nxt.period = P_FIRST;
                s_nxt.result = {s_r.sar[RES_W-1:1], comp_bit};
                s_nxt.done   = 1'b1;
                s_nxt.sar    = SAR_CLEAR;
            end else begin
                s_nxt.period = s_r.period + 4'h1;
                if (s_r.period >= P_MSB) begin
                    // Keep or clear the trial bit, then trial the next one
                    s_nxt.sar[k]      = comp_bit;
                    s_nxt.sar[k - 1'b1] = 1'b1;
                end
            end
        end

        // Bus: one cycle to answer, write lands with the ack
        s_nxt.ack = bus_req;
        if (bus_req) begin
            s_nxt.rdat = 32'h0000_0000;            // Unmapped reads as zero
            if (wb_req.adr == ADR_CTRL) begin
                s_nxt.rdat[CTRL_EXT_BIT] = s_r.ext_sel;
                if (wb_req.we && wb_req.sel[0]) begin
                    s_nxt.ext_sel = wb_req.dat[CTRL_EXT_BIT];
                end
            end else if (wb_req.adr == ADR_STATUS) begin
                s_nxt.rdat[ST_DONE_BIT]              = s_r.done;
                s_nxt.rdat[ST_PER_LSB +: 4]          = s_r.period;
                s_nxt.rdat[ST_HALT_BIT]              = s_r.hold;
            end else if (wb_req.adr == ADR_RESULT) begin
                s_nxt.rdat[RES_W-1:0] = s_r.result;
            end
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    // Comes out of reset in period 1 with the start gate open
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r         <= '0;
            s_r.period  <= P_FIRST;
            s_r.ext_sel <= CTRL_EXT_RST;
            s_r.start_conv_n_s  <= 2'b11;
            s_r.oem_s   <= 2'b11;
            s_r.oel_s   <= 2'b11;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Data only moves at the period 15 edge, the pad enables follow the pins
    assign result_o       = s_r.result;
    assign result_hi_oe_n = s_r.oem_s[1];
    assign result_lo_oe_n = s_r.oel_s[1];
    assign conv_done_flag = s_r.done;
    assign wb_dat_o       = s_r.rdat;
    assign wb_ack_o       = s_r.ack;

    // Tracking lasts through a halt, since the halt sits in period 2
    always_comb begin
        afe.track   = (s_r.period <= P_TRACK_LAST);
        afe.autobal = (s_r.period <= P_TRACK_LAST);
        afe.trial   = afe.track ? SAR_CLEAR : s_r.sar;
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence seq_last_edge;
        tick && !s_r.hold && s_r.period == P_LAST;
    endsequence

    sequence seq_ready;
        s_r.period == P_FIRST && conv_done_flag;
    endsequence

    sequence seq_track_edge;
        tick && s_r.period == P_TRACK_LAST;
    endsequence

    a_done_rise: assert property (seq_last_edge |=> seq_ready)
        else $error("done flag not raised after period 15");

    a_done_fall_place: assert property ($fell(conv_done_flag) |-> s_r.period == P_GATE)
        else $error("done flag fell outside period 2");

    // Synchronisers hold their reset level for two edges after release
    a_hi_enable: assert property ($past(rst_b, 2)
                                  |-> result_hi_oe_n == $past(high_byte_out_en_n, 2))
        else $error("upper enable does not follow its pin");

    a_lo_enable: assert property ($past(rst_b, 2)
                                  |-> result_lo_oe_n == $past(low_nibble_out_en_n, 2))
        else $error("lower enable does not follow its pin");

    a_sar_cleared: assert property (seq_track_edge |=> s_r.sar == SAR_MSB_ONLY
                                    && s_r.period == P_MSB)
        else $error("trial word not cleared before MSB trial");

    a_track_off: assert property (s_r.period >= P_MSB |-> !afe.track && !afe.autobal)
        else $error("input connected during bit trials");

    a_edge_only: assert property (s_r.period != $past(s_r.period) |-> $past(tick))
        else $error("period moved without a clock edge");

    a_step_one: assert property (tick && !s_r.hold && s_r.period != P_LAST
                                 |=> s_r.period == $past(s_r.period) + 4'h1)
        else $error("period did not step by one");

    a_result_moves: assert property (result_o != $past(result_o)
                                     |-> $past(s_r.period) == P_LAST && $past(tick))
        else $error("result changed outside the period 15 edge");

    a_halt_flag: assert property (s_r.hold |-> conv_done_flag && s_r.period == P_GATE)
        else $error("halt without ready flag or outside period 2");

    a_halt_stays: assert property (s_r.hold && !start_conv_n_low |=> s_r.hold)
        else $error("halt released without start");

    a_msb_kept: assert property (tick && !s_r.hold && s_r.period == P_MSB
                                 |=> s_r.sar[RES_W-1] == $past(comp_bit))
        else $error("MSB decision not stored");

endmodule

// ===== rtl/sas_pkg.sv
package sas_pkg;

    // ********************************************************
    // Conversion sequence
    // ********************************************************
    localparam int unsigned RES_W        = 12;
    localparam logic [3:0]  P_FIRST      = 4'h1;  // Tracking starts, result shown
    localparam logic [3:0]  P_GATE       = 4'h2;  // Start gate, clock may halt here
    localparam logic [3:0]  P_TRACK_LAST = 4'h3;
    localparam logic [3:0]  P_MSB        = 4'h4;  // First bit trial
    localparam logic [3:0]  P_LAST       = 4'hF;  // LSB trial and result transfer
    localparam logic [11:0] SAR_CLEAR    = 12'h000;
    localparam logic [11:0] SAR_MSB_ONLY = 12'h800;

    // ********************************************************
    // Internal conversion clock
    // ********************************************************
    localparam int unsigned REF_CLK_HZ = 25_000_000;
    localparam int unsigned INT_CLK_HZ = 300_000;
    localparam int unsigned INT_DIV    = REF_CLK_HZ / INT_CLK_HZ;

    // ********************************************************
    // Register map, byte addresses
    // ********************************************************
    localparam int unsigned ADR_W      = 4;
    localparam logic [3:0]  ADR_CTRL   = 4'h0;
    localparam logic [3:0]  ADR_STATUS = 4'h4;
    localparam logic [3:0]  ADR_RESULT = 4'h8;
    localparam int unsigned CTRL_EXT_BIT = 0;
    localparam int unsigned ST_DONE_BIT  = 0;
    localparam int unsigned ST_PER_LSB   = 1;
    localparam int unsigned ST_HALT_BIT  = 5;
    localparam logic        CTRL_EXT_RST = 1'b0;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [3:0]       sel;
        logic [31:0]      dat;
    } sas_wb_req_t;

    typedef struct packed {
        logic             track;    // Sampling network on analog_in
        logic             autobal;  // Comparator autobalance
        logic [RES_W-1:0] trial;    // Capacitors tied to the upper reference
    } sas_afe_t;

endpackage

// ===== rtl/sas_conv_clk.sv
`timescale 1ns/1ps
module sas_conv_clk import sas_pkg::*; #(
    parameter int unsigned DIV = INT_DIV
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Control
    input  wire logic ext_sel,
    input  wire logic run,
    // External conversion clock pin
    input  wire logic ext_clk_pin,
    // Rising edge of the conversion clock
    output logic      tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        xs1;
        logic        xs2;
        logic        xs3;
        logic        tick;
    } sas_clk_st_t;

    sas_clk_st_t s_r;
    sas_clk_st_t s_nxt;

    // ********************************************************
    // Divider and external edge detect
    // ********************************************************
    // Internal clock restarts from zero, so a halted period 2 is stretched
    always_comb begin
        s_nxt      = s_r;
        s_nxt.xs1  = ext_clk_pin;
        s_nxt.xs2  = s_r.xs1;
        s_nxt.xs3  = s_r.xs2;
        s_nxt.tick = 1'b0;
        if (ext_sel) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = s_r.xs2 & ~s_r.xs3;  // External clock never halts here
        end else if (!run) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt == 16'(DIV - 1)) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule

// ===== verif/sas_host_model.sv
`timescale 1ns/1ps
module sas_host_model import sas_pkg::*; (
    // Analog side
    input  wire logic [RES_W-1:0] analog_code,
    input  wire sas_afe_t         afe,
    output logic                  comp_hi,
    // Host data capture
    input  wire logic             conv_done_flag,
    input  wire logic [RES_W-1:0] data_bus,
    output logic [RES_W-1:0]      host_word
);
    // Ideal comparator, high keeps the trial bit
    assign comp_hi = (analog_code >= afe.trial);

    // Capture on falling flag, bus is steady then
    always @(negedge conv_done_flag) begin
        host_word <= data_bus;
    end
endmodule

// ===== verif/sas_seq_tb.sv
`timescale 1ns/1ps
module sas_seq_tb import sas_pkg::*;;
    localparam int unsigned TDIV = 4;
    logic              ref_clk;
    logic              rst_b        = 1'b0;
    logic              start_conv_n = 1'b0;
    logic              ext_clk_pin  = 1'b0;
    logic              ext_run      = 1'b0;
    logic              hi_en_n      = 1'b0;
    logic              lo_en_n      = 1'b0;
    sas_wb_req_t       wb_req       = '0;
    logic [RES_W-1:0]  analog_code  = 12'h123;
    logic [31:0]       wb_dat_o;
    logic [31:0]       rd;
    logic              wb_ack_o;
    logic              conv_done_flag;
    logic              result_hi_oe_n;
    logic              result_lo_oe_n;
    logic              comp_hi;
    logic [RES_W-1:0]  result_o;
    logic [RES_W-1:0]  host_word;
    logic [RES_W-1:0]  prev;
    sas_afe_t          afe;
    wire  [RES_W-1:0]  data_bus;
    int                error_cnt    = 0;
    int                cmp_count    = 0;
    int                cyc_cnt      = 0;
    int                ext_div      = 0;

    // Pads: each group floats while its enable is high
    assign data_bus[11:4] = result_hi_oe_n ? 8'hZZ : result_o[11:4];
    assign data_bus[3:0]  = result_lo_oe_n ? 4'hZ : result_o[3:0];

    sas_seq #(.DIV(TDIV)) i_sas_seq (
        .ref_clk(ref_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .start_conv_n(start_conv_n), .ext_clk_pin(ext_clk_pin),
        .conv_done_flag(conv_done_flag), .high_byte_out_en_n(hi_en_n),
        .low_nibble_out_en_n(lo_en_n), .result_o(result_o),
        .result_hi_oe_n(result_hi_oe_n), .result_lo_oe_n(result_lo_oe_n),
        .comp_hi(comp_hi), .afe(afe));

    sas_host_model i_sas_host_model (
        .analog_code(analog_code), .afe(afe), .comp_hi(comp_hi),
        .conv_done_flag(conv_done_flag), .data_bus(data_bus), .host_word(host_word));

    // ****************************************
    // Clocks and watchdog
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // External clock, period 12 ref_clk, still until used, then never halted
    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (ext_run) begin
            ext_div <= (ext_div == 5) ? 0 : ext_div + 1;
            if (ext_div == 5) ext_clk_pin <= ~ext_clk_pin;
        end
        if (cyc_cnt == 20000) begin
            error_cnt++;
            complete_run;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Edges until the flag is sampled at lvl, bounded
    // Read mid-cycle: the value seen is the one the next rising edge samples
    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (conv_done_flag !== lvl && n < 1000);
        if (conv_done_flag !== lvl) begin
            error_cnt++;
        end
        @(posedge ref_clk);
    endtask

    // Classic single cycle, held until ack is sampled
    // Ack and data are read mid-cycle, so no race with the edge that sets them
    task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int   n;
        logic ack_seen;
        n        = 0;
        ack_seen = 1'b0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: a, sel: 4'hF, dat: d};
        do begin
            @(negedge ref_clk);
            ack_seen = (wb_ack_o === 1'b1);
            rd       = wb_dat_o;
            n++;
            @(posedge ref_clk);
        end while (!ack_seen && n < 50);
        if (!ack_seen) begin
            error_cnt++;
        end
        wb_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic free_run;
        int nf;
        int nr;
        logic [RES_W-1:0] vals [5];
        vals = '{12'hFFF, 12'h000, 12'h800, 12'h7FF, 12'hA5A};
        prev = 12'h123;
        wait_lvl(1'b1, nr);
        chk(result_o, prev);
        foreach (vals[i]) begin
            wait_lvl(1'b0, nf);
            chk(nf, TDIV);
            chk(host_word, prev);
            analog_code <= vals[i];
            repeat (20) @(posedge ref_clk);
            chk(result_o, prev);
            wait_lvl(1'b1, nr);
            chk(nf + nr + 20, 15 * TDIV);
            chk(data_bus, vals[i]);
            prev = vals[i];
        end
    endtask

    task automatic out_en;
        for (int i = 0; i < 4; i++) begin
            hi_en_n <= i[1];
            lo_en_n <= i[0];
            repeat (4) @(posedge ref_clk);
            chk(data_bus[11:4], i[1] ? 8'hZZ : prev[11:4]);
            chk(data_bus[3:0], i[0] ? 4'hZ : prev[3:0]);
        end
        wb(1'b0, ADR_RESULT, 32'h0);
        chk(rd, {20'h0, prev});
        wb(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
    endtask

    // Start released: park in period 2, then one shot
    task automatic single_shot;
        int n;
        start_conv_n <= 1'b1;
        analog_code <= 12'h5A3;
        repeat (30 * TDIV) @(posedge ref_clk);
        chk(conv_done_flag, 1'b1);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(rd[ST_HALT_BIT], 1'b1);
        chk(afe.track, 1'b1);
        chk(afe.autobal, 1'b1);
        start_conv_n <= 1'b0;
        wait_lvl(1'b0, n);
        chk(n <= 5, 1'b1);
        start_conv_n <= 1'b1;
        repeat (8 * TDIV) @(posedge ref_clk);
        chk(afe.track, 1'b0);
        chk(afe.autobal, 1'b0);
        start_conv_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        start_conv_n <= 1'b1;
        wait_lvl(1'b1, n);
        chk(result_o, 12'h5A3);
        repeat (20 * TDIV) @(posedge ref_clk);
        chk(conv_done_flag, 1'b1);
    endtask

    task automatic ext_mode;
        int nf;
        int nr;
        wb(1'b1, ADR_CTRL, 32'h1);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(rd[CTRL_EXT_BIT], 1'b1);
        analog_code <= 12'h3C5;
        ext_run <= 1'b1;
        start_conv_n <= 1'b0;
        wait_lvl(1'b0, nf);
        wait_lvl(1'b1, nr);
        chk(result_o, 12'h3C5);
        wait_lvl(1'b0, nf);
        wait_lvl(1'b1, nr);
        chk(nf + nr, 15 * 12);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        chk(conv_done_flag, 1'b0);
        chk(result_hi_oe_n, 1'b1);
        chk(afe.track, 1'b1);
        rst_b <= 1'b1;
        free_run;
        out_en;
        single_shot;
        ext_mode;
        complete_run;
    end
endmodule
